// ==== design/sfifo_top.v ====
/*
  Sample buffer with trigger modes: a 128-record store of pressure and
  temperature, its mode control, level and flag status, interrupt routing
  and the serial register port through which the host reaches it.
  Assumes samples and the interrupt-active level come from logic on clk,
  and the serial pins come from the host, asynchronous to clk.
*/
`timescale 1ns/10ps
`include "sfifo_consts.vh"
module sfifo_top (
  input  wire        clk,
  input  wire        rst,
  input  wire        cs_n_pin,
  input  wire        spc_pin,
  input  wire        sdi_pin,
  output wire        sdo_pin,
  output wire        sdo_oe_n,
  input  wire        sample_valid,
  input  wire [23:0] sample_pressure,
  input  wire [15:0] sample_temperature,
  input  wire        interrupt_active_flag,
  output reg  [7:0]  threshold_irq_cfg,
  output reg         data_ready_irq_pin
);
  // Effective buffer behaviour after the trigger has been resolved.
  localparam BEH_BYPASS = 2'h0;
  localparam BEH_FIFO   = 2'h1;
  localparam BEH_CONT   = 2'h2;

  // Software registers.
  reg  [7:0]  route_q;           // Interrupt routing enables.
  reg  [7:0]  ctl_q;             // Mode control.
  reg  [7:0]  wtm_q;             // Watermark level in low seven bits.

  // Live sample copy, refreshed on every new sample.
  reg  [23:0] live_press_q;
  reg  [15:0] live_temp_q;

  // Buffer state.
  reg  [6:0]  wr_ptr_q;          // Next slot to write.
  reg  [6:0]  rd_ptr_q;          // Oldest unread slot.
  reg  [7:0]  unread_count_q;    // Unread records, 0 to 128.
  reg         overrun_flag_q;    // A record was overwritten unread.
  reg         trig_seen_q;       // Trigger rose since leaving bypass.
  reg         ia_prev_q;         // Trigger level one cycle ago.
  reg  [7:0]  rd_data_q;         // Byte handed to the serial port.

  // Next-state terms.
  reg  [1:0]  beh;
  reg         mem_we;
  reg  [6:0]  mem_waddr;
  reg  [6:0]  wr_ptr_d;
  reg  [6:0]  rd_ptr_d;
  reg  [7:0]  count_d;
  reg         ovr_set;
  reg  [7:0]  rd_mux;

  // Serial port side.
  wire [6:0]  reg_addr;
  wire        wr_stb;
  wire [7:0]  wr_data;
  wire        rd_req;
  wire        rd_done;
  wire [39:0] mem_rdata;

  // Mode code made of the trigger bit and the two mode bits.
  wire [2:0]  mode_code = {ctl_q[`SFIFO_CTL_TRIG], ctl_q[1:0]};
  wire        code_bypass = (ctl_q[1:0] == 2'h0);
  wire        code_trig = ctl_q[`SFIFO_CTL_TRIG] & ~code_bypass;
  wire        ia_rise = interrupt_active_flag & ~ia_prev_q;

  // Usable depth; a zero watermark leaves the full depth in force.
  wire        stop_at_watermark = ctl_q[`SFIFO_CTL_STOP];
  wire [7:0]  depth_lim = (stop_at_watermark && (wtm_q[6:0] != 7'h00)) ?
                          {1'b0, wtm_q[6:0]} : `SFIFO_DEPTH;

  // Status terms.
  wire        watermark_flag = (wtm_q[6:0] != 7'h00) &&
                               (unread_count_q >= {1'b0, wtm_q[6:0]});
  wire        full_flag = (unread_count_q >= depth_lim);
  wire [7:0]  flag_status = {watermark_flag, overrun_flag_q, full_flag,
                             5'h00};

  // An entry leaves only after its last byte has gone out.
  wire        pop = rd_done && (reg_addr == `SFIFO_A_BUF_TH) &&
                    (unread_count_q != 8'h00) &&
                    (beh != BEH_BYPASS);
  wire [7:0]  count_after_pop = unread_count_q - {7'h00, pop};

  // Serial register port.
  sfifo_spi_slave u_port (
    .clk      (clk),
    .rst      (rst),
    .cs_n_pin (cs_n_pin),
    .spc_pin  (spc_pin),
    .sdi_pin  (sdi_pin),
    .rd_data  (rd_data_q),
    .reg_addr (reg_addr),
    .wr_stb   (wr_stb),
    .wr_data  (wr_data),
    .rd_req   (rd_req),
    .rd_done  (rd_done),
    .sdo_pin  (sdo_pin),
    .sdo_oe_n (sdo_oe_n)
  );

  // Record store; pressure in the low 24 bits, temperature above.
  sfifo_mem u_mem (
    .clk   (clk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata ({sample_temperature, sample_pressure}),
    .raddr (rd_ptr_q),
    .rdata (mem_rdata)
  );

  // Resolve the mode code and trigger history into one behaviour.
  always @* begin
    case (mode_code)
      3'h0: begin
        beh = BEH_BYPASS;
      end
      3'h4: begin
        beh = BEH_BYPASS;
      end
      3'h1: begin
        beh = BEH_FIFO;
      end
      3'h3: begin
        beh = BEH_CONT;
      end
      3'h2: begin
        // Unlisted code; treated as continuous rather than lost data.
        beh = BEH_CONT;
      end
      3'h5: begin
        beh = trig_seen_q ? BEH_FIFO : BEH_BYPASS;
      end
      3'h6: begin
        beh = trig_seen_q ? BEH_CONT : BEH_BYPASS;
      end
      3'h7: begin
        beh = trig_seen_q ? BEH_FIFO : BEH_CONT;
      end
      default: begin
        beh = BEH_BYPASS;
      end
    endcase
  end

  // Pointer and count update for one new sample and at most one pop.
  always @* begin
    mem_we    = 1'b0;
    mem_waddr = wr_ptr_q;
    wr_ptr_d  = wr_ptr_q;
    rd_ptr_d  = rd_ptr_q + {6'h00, pop};
    count_d   = count_after_pop;
    ovr_set   = 1'b0;
    // Pointers wrap over all 128 slots; a cut depth only moves the count limit.
    case (beh)
      BEH_BYPASS: begin
        // Slot zero only, always overwritten; nothing counts as unread.
        mem_we    = sample_valid;
        mem_waddr = 7'h00;
        wr_ptr_d  = 7'h00;
        rd_ptr_d  = 7'h00;
        count_d   = 8'h00;
      end
      BEH_FIFO: begin
        // Once the usable depth is reached, new samples are dropped.
        if (sample_valid && (count_after_pop < depth_lim)) begin
          mem_we   = 1'b1;
          wr_ptr_d = wr_ptr_q + 7'h01;
          count_d  = count_after_pop + 8'h01;
        end
      end
      BEH_CONT: begin
        if (sample_valid) begin
          mem_we   = 1'b1;
          wr_ptr_d = wr_ptr_q + 7'h01;
          if (count_after_pop < depth_lim) begin
            count_d = count_after_pop + 8'h01;
          end else begin
            // Full: the oldest record is given up for the newest.
            rd_ptr_d = rd_ptr_d + 7'h01;
            ovr_set  = 1'b1;
          end
        end
      end
      default: begin
        count_d = 8'h00;
      end
    endcase
  end

  // Read data select; buffered bytes come from the oldest record.
  always @* begin
    case (reg_addr)
      `SFIFO_A_THR_CFG: begin
        rd_mux = threshold_irq_cfg;
      end
      `SFIFO_A_ROUTE: begin
        rd_mux = route_q;
      end
      `SFIFO_A_CTL: begin
        rd_mux = ctl_q;
      end
      `SFIFO_A_WTM: begin
        rd_mux = wtm_q;
      end
      `SFIFO_A_SRC: begin
        rd_mux = {5'h00, interrupt_active_flag, 2'h0};
      end
      `SFIFO_A_ST1: begin
        rd_mux = unread_count_q;
      end
      `SFIFO_A_ST2: begin
        rd_mux = flag_status;
      end
      `SFIFO_A_PL: begin
        rd_mux = live_press_q[7:0];
      end
      `SFIFO_A_PM: begin
        rd_mux = live_press_q[15:8];
      end
      `SFIFO_A_PH: begin
        rd_mux = live_press_q[23:16];
      end
      `SFIFO_A_TL: begin
        rd_mux = live_temp_q[7:0];
      end
      `SFIFO_A_TH: begin
        rd_mux = live_temp_q[15:8];
      end
      `SFIFO_A_BUF_PL: begin
        rd_mux = mem_rdata[7:0];
      end
      `SFIFO_A_BUF_PM: begin
        rd_mux = mem_rdata[15:8];
      end
      `SFIFO_A_BUF_PH: begin
        rd_mux = mem_rdata[23:16];
      end
      `SFIFO_A_BUF_TL: begin
        rd_mux = mem_rdata[31:24];
      end
      `SFIFO_A_BUF_TH: begin
        rd_mux = mem_rdata[39:32];
      end
      default: begin
        // Unmapped addresses read as zero.
        rd_mux = 8'h00;
      end
    endcase
  end

  // Software writes; read-only and unmapped addresses ignore them.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      threshold_irq_cfg <= `SFIFO_RST_BYTE;
      route_q           <= `SFIFO_RST_BYTE;
      ctl_q             <= `SFIFO_RST_BYTE;
      wtm_q             <= `SFIFO_RST_BYTE;
    end else if (wr_stb) begin
      case (reg_addr)
        `SFIFO_A_THR_CFG: begin
          threshold_irq_cfg <= wr_data;
        end
        `SFIFO_A_ROUTE: begin
          // Enables reach the pin one clock after the write.
          route_q <= wr_data;
        end
        `SFIFO_A_CTL: begin
          // A direct jump between buffering modes keeps the old pointers;
          // the host is expected to pass through bypass first.
          ctl_q <= wr_data;
        end
        `SFIFO_A_WTM: begin
          // Bit 7 means nothing and reads back as zero.
          wtm_q <= {1'b0, wr_data[6:0]};
        end
        default: begin
          wtm_q <= wtm_q;
        end
      endcase
    end
  end

  // Buffer pointers, count, sticky flags and the live sample copy.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_q       <= 7'h00;
      rd_ptr_q       <= 7'h00;
      unread_count_q <= 8'h00;
      overrun_flag_q <= 1'b0;
      trig_seen_q    <= 1'b0;
      ia_prev_q      <= 1'b0;
      live_press_q   <= 24'h000000;
      live_temp_q    <= 16'h0000;
    end else begin
      wr_ptr_q       <= wr_ptr_d;
      rd_ptr_q       <= rd_ptr_d;
      unread_count_q <= count_d;
      ia_prev_q      <= interrupt_active_flag;
      // The trigger is remembered until the host selects bypass again.
      // A level already high when the code is written is no rise, so no trigger.
      if (code_bypass) begin
        trig_seen_q <= 1'b0;
      end else if (code_trig && ia_rise) begin
        trig_seen_q <= 1'b1;
      end
      // A new overwrite wins over a clear in the same cycle.
      if (ovr_set) begin
        overrun_flag_q <= 1'b1;
      end else if ((beh == BEH_BYPASS) || pop) begin
        overrun_flag_q <= 1'b0;
      end
      if (sample_valid) begin
        live_press_q <= sample_pressure;
        live_temp_q  <= sample_temperature;
      end
    end
  end

  // Read byte capture and interrupt pin, both registered outputs.
  // The pin trails the flags by one clock, so status and pin may briefly differ.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_q          <= 8'h00;
      data_ready_irq_pin <= 1'b0;
    end else begin
      if (rd_req) begin
        rd_data_q <= rd_mux;
      end
      // The watermark route is what lets a continuous-mode host drain
      // the buffer before it starts overwriting.
      data_ready_irq_pin <=
        (watermark_flag & route_q[`SFIFO_RT_WTM]) |
        (overrun_flag_q & route_q[`SFIFO_RT_OVR]) |
        (full_flag & route_q[`SFIFO_RT_FULL]);
    end
  end
endmodule // sfifo_top

// ==== include/sfifo_consts.vh ====
/*
  Constants of the sample buffer: register addresses, field positions,
  the buffer depth and reset values. Definitions only; included by bare name.
*/
// Notes on behaviour
// - 128 slots, each a 40-bit pressure/temperature record.
// - Nonzero mode bits enable; trigger bit plus mode pick.
// - Watermark flag when count >= level, never at zero.
// - Overrun flag when an unread slot is overwritten.
// - Eight-bit unread count, 0 empty, 128 full.
// - Watermark, overrun, full each routable to interrupt pin.
// - Codes 000 and 100 are bypass, buffer stays empty.
// - Entering bypass flushes contents and clears count.
// - Bypass uses slot zero only, newest overwrites it.
// - Code 001 stores samples until full, then stops.
// - Stop-at-watermark bit limits depth to watermark level.
// - Code 011 stores continuously, oldest unread read first.
// - Continuous count equals new samples held.
// - Code 101: bypass, then stop-when-full after first trigger.
// - Code 110: bypass, then continuous after trigger.
// - Code 111: continuous, then stop-when-full after trigger.
// - Output bytes 78h..7Ch, burst address wraps 7Ch to 78h.
// - Continuous mode watermark interrupt frees slots.
// - Buffered pressure is 24-bit two's complement.
// - Buffered temperature is 16-bit two's complement.
`ifndef SFIFO_CONSTS_VH
`define SFIFO_CONSTS_VH
`define SFIFO_A_THR_CFG  7'h0B
`define SFIFO_A_ROUTE    7'h12
`define SFIFO_A_CTL      7'h13
`define SFIFO_A_WTM      7'h14
`define SFIFO_A_SRC      7'h24
`define SFIFO_A_ST1      7'h25
`define SFIFO_A_ST2      7'h26
`define SFIFO_A_PL       7'h28
`define SFIFO_A_PM       7'h29
`define SFIFO_A_PH       7'h2A
`define SFIFO_A_TL       7'h2B
`define SFIFO_A_TH       7'h2C
`define SFIFO_A_BUF_PL   7'h78
`define SFIFO_A_BUF_PM   7'h79
`define SFIFO_A_BUF_PH   7'h7A
`define SFIFO_A_BUF_TL   7'h7B
`define SFIFO_A_BUF_TH   7'h7C
`define SFIFO_CTL_STOP   3
`define SFIFO_CTL_TRIG   2
`define SFIFO_RT_FULL    5
`define SFIFO_RT_WTM     4
`define SFIFO_RT_OVR     3
`define SFIFO_ST2_WTM    7
`define SFIFO_ST2_OVR    6
`define SFIFO_ST2_FULL   5
`define SFIFO_SRC_IA     2
`define SFIFO_DEPTH      8'h80
`define SFIFO_RST_BYTE   8'h00
`endif

// ==== design/sfifo_mem.v ====
/*
  Sample storage array of 128 records of 40 bits.
  Assumes one writer and a combinational read by the owner on one clock.
*/
`timescale 1ns/10ps
module sfifo_mem (
  input  wire        clk,
  input  wire        we,
  input  wire [6:0]  waddr,
  input  wire [39:0] wdata,
  input  wire [6:0]  raddr,
  output wire [39:0] rdata
);
  // Storage is left without reset; the pointers decide what is valid.
  reg [39:0] slot_q [0:127];

  // Write port.
  always @(posedge clk) begin
    if (we) begin
      slot_q[waddr] <= wdata;
    end
  end

  // Read is combinational; the owner registers the chosen byte.
  assign rdata = slot_q[raddr];
endmodule // sfifo_mem

// ==== design/sfifo_spi_slave.v ====
/*
  Four-wire serial register port, clock idle high, data taken on the
  rising edge and driven on the falling edge. The first byte carries the
  read flag in bit 7 and the register address below it.
  Assumes the pins are asynchronous to clk and the serial clock is at
  least about eight times slower than clk.
*/
`timescale 1ns/10ps
`include "sfifo_consts.vh"
module sfifo_spi_slave (
  input  wire       clk,
  input  wire       rst,
  input  wire       cs_n_pin,
  input  wire       spc_pin,
  input  wire       sdi_pin,
  input  wire [7:0] rd_data,
  output reg  [6:0] reg_addr,
  output reg        wr_stb,
  output reg  [7:0] wr_data,
  output reg        rd_req,
  output reg        rd_done,
  output reg        sdo_pin,
  output reg        sdo_oe_n
);
  reg       cs_s1_q, cs_s2_q;   // Chip select synchroniser.
  reg       spc_s1_q, spc_s2_q; // Serial clock synchroniser.
  reg       spc_s3_q;           // Previous synchronised clock level.
  reg       sdi_s1_q, sdi_s2_q; // Serial data synchroniser.
  reg [2:0] bit_cnt_q;          // Bit position within a byte.
  reg [6:0] in_sh_q;            // Incoming bits so far.
  reg       first_q;            // Next byte is the command byte.
  reg       rnw_q;              // Current frame is a read.
  reg       inc_q;              // Advance address next cycle.
  reg       load_q;             // Load read byte into shifter.
  reg [7:0] out_sh_q;           // Outgoing byte.
  wire      rise = spc_s2_q & ~spc_s3_q;
  wire      fall = ~spc_s2_q & spc_s3_q;
  wire [7:0] in_byte = {in_sh_q, sdi_s2_q};

  // Burst address step; the buffered output block wraps onto itself.
  function [6:0] next_addr;
    input [6:0] a;
    begin
      if (a == `SFIFO_A_BUF_TH) begin
        next_addr = `SFIFO_A_BUF_PL;
      end else begin
        next_addr = a + 7'h01;
      end
    end
  endfunction

  // Shifting, framing and the request pipeline toward the register file.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_s1_q   <= 1'b1;
      cs_s2_q   <= 1'b1;
      spc_s1_q  <= 1'b1;
      spc_s2_q  <= 1'b1;
      spc_s3_q  <= 1'b1;
      sdi_s1_q  <= 1'b0;
      sdi_s2_q  <= 1'b0;
      bit_cnt_q <= 3'h0;
      in_sh_q   <= 7'h00;
      first_q   <= 1'b1;
      rnw_q     <= 1'b0;
      inc_q     <= 1'b0;
      load_q    <= 1'b0;
      out_sh_q  <= 8'h00;
      reg_addr  <= 7'h00;
      wr_stb    <= 1'b0;
      wr_data   <= 8'h00;
      rd_req    <= 1'b0;
      rd_done   <= 1'b0;
      sdo_pin   <= 1'b0;
      sdo_oe_n  <= 1'b1;
    end else begin
      cs_s1_q  <= cs_n_pin;
      cs_s2_q  <= cs_s1_q;
      spc_s1_q <= spc_pin;
      spc_s2_q <= spc_s1_q;
      spc_s3_q <= spc_s2_q;
      sdi_s1_q <= sdi_pin;
      sdi_s2_q <= sdi_s1_q;
      wr_stb   <= 1'b0;
      rd_done  <= 1'b0;
      rd_req   <= 1'b0;
      inc_q    <= 1'b0;
      load_q   <= rd_req;
      sdo_oe_n <= cs_s2_q;
      // Advance after each data byte; a read then fetches the next byte.
      if (inc_q) begin
        reg_addr <= next_addr(reg_addr);
        rd_req   <= rnw_q;
      end
      if (load_q) begin
        out_sh_q <= rd_data;
      end
      if (cs_s2_q) begin
        // Deselected: the next byte is a fresh command byte.
        bit_cnt_q <= 3'h0;
        first_q   <= 1'b1;
      end else if (rise) begin
        bit_cnt_q <= bit_cnt_q + 3'h1;
        in_sh_q   <= in_byte[6:0];
        if (bit_cnt_q == 3'h7) begin
          if (first_q) begin
            first_q  <= 1'b0;
            reg_addr <= in_byte[6:0];
            rnw_q    <= in_byte[7];
            rd_req   <= in_byte[7];
          end else if (rnw_q) begin
            rd_done <= 1'b1;
            inc_q   <= 1'b1;
          end else begin
            wr_stb  <= 1'b1;
            wr_data <= in_byte;
            inc_q   <= 1'b1;
          end
        end
      end else if (fall) begin
        sdo_pin  <= out_sh_q[7];
        out_sh_q <= {out_sh_q[6:0], 1'b0};
      end
    end
  end
endmodule // sfifo_spi_slave

// ==== sim/sfifo_chk.sv ====
/*
  Pin checker of the sample buffer: chip-select, data-out and interrupt timing.
  Assumes it is bound to sfifo_top and sees only that module's ports.
*/
`timescale 1ns/10ps
module sfifo_chk (
  input wire        clk,
  input wire        rst,
  input wire        cs_n_pin,
  input wire        spc_pin,
  input wire        sdi_pin,
  input wire        sdo_pin,
  input wire        sdo_oe_n,
  input wire        sample_valid,
  input wire [23:0] sample_pressure,
  input wire [15:0] sample_temperature,
  input wire        interrupt_active_flag,
  input wire [7:0]  threshold_irq_cfg,
  input wire        data_ready_irq_pin
);
  logic [3:0] desel_q; // Cycles with chip select high, saturating.
  logic [3:0] calm_q;  // Cycles with no frame and no sample, saturating.

  // Quiet-time counters; a long quiet spell means nothing may change state.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      desel_q <= 4'h0;
      calm_q  <= 4'h0;
    end else begin
      desel_q <= !cs_n_pin ? 4'h0 : (desel_q == 4'hF ? desel_q : desel_q + 4'h1);
      calm_q  <= (!cs_n_pin || sample_valid) ? 4'h0 : (calm_q == 4'hF ? calm_q : calm_q + 4'h1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_desel;
    cs_n_pin [*4];
  endsequence
  sequence s_sel;
    (!cs_n_pin) [*4];
  endsequence
  sequence s_spc_high;
    (!cs_n_pin && spc_pin) [*6];
  endsequence

  AST_OE_IDLE: assert property (s_desel |-> sdo_oe_n)
    else $error("data out enabled while deselected");
  AST_OE_SEL: assert property (s_sel |-> !sdo_oe_n)
    else $error("data out not enabled while selected");
  AST_OE_RISE: assert property (s_sel ##1 $rose(cs_n_pin) |-> ##[1:4] $rose(sdo_oe_n))
    else $error("data out enable late after deselect");
  AST_OE_LATE: assert property (s_desel ##1 !cs_n_pin |-> sdo_oe_n ##1 sdo_oe_n)
    else $error("data out enabled too early after select");
  AST_SDO_HOLD: assert property (s_spc_high |=> $stable(sdo_pin))
    else $error("data out moved while serial clock high");
  AST_IRQ_QUIET: assert property (calm_q >= 4'h6 |-> $stable(data_ready_irq_pin))
    else $error("interrupt pin moved with no cause");
  AST_CFG_QUIET: assert property (desel_q >= 4'h8 |=> $stable(threshold_irq_cfg))
    else $error("config copy moved outside a frame");
  AST_CFG_FRAME: assert property ($changed(threshold_irq_cfg) |-> desel_q < 4'h3)
    else $error("config copy changed long after a frame");
endmodule // sfifo_chk

bind sfifo_top sfifo_chk u_chk (
  .clk(clk), .rst(rst), .cs_n_pin(cs_n_pin), .spc_pin(spc_pin), .sdi_pin(sdi_pin),
  .sdo_pin(sdo_pin), .sdo_oe_n(sdo_oe_n), .sample_valid(sample_valid),
  .sample_pressure(sample_pressure), .sample_temperature(sample_temperature),
  .interrupt_active_flag(interrupt_active_flag), .threshold_irq_cfg(threshold_irq_cfg),
  .data_ready_irq_pin(data_ready_irq_pin)
);

// ==== sim/sfifo_host.sv ====
/*
  Host model: four-wire serial master, clock idle high, bits out on the fall.
  Assumes clk is the system clock; the serial clock averages 125 ns.
*/
`timescale 1ns/10ps
module sfifo_host (
  input  wire clk,
  output reg  cs_n_pin,
  output reg  spc_pin,
  output reg  sdi_pin,
  input  wire sdo_pin,
  input  wire sdo_oe_n
);
  reg [7:0] rbuf [0:639]; // Bytes of the last burst, room for a full drain.

  initial begin
    cs_n_pin = 1'b1;
    spc_pin  = 1'b1;
    sdi_pin  = 1'b0;
  end

  // One byte; low phase 6 cycles, high 6 or 7 so the period averages 125 ns.
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    integer i;
    for (i = 7; i >= 0; i = i - 1) begin
      @(posedge clk);
      spc_pin <= 1'b0;
      sdi_pin <= tx[i];
      repeat (6) @(posedge clk);
      spc_pin <= 1'b1;
      rx[i] = sdo_oe_n ? 1'bx : sdo_pin; // An undriven line reads as unknown.
      repeat (5 + i % 2) @(posedge clk);
    end
  endtask

  // Command byte, then n bytes of write data or read slots.
  task automatic frame(input logic [7:0] cmd, input logic [7:0] wd, input integer n);
    integer k;
    logic [7:0] rx;
    @(posedge clk);
    cs_n_pin <= 1'b0;
    repeat (4) @(posedge clk);
    xbyte(cmd, rx);
    for (k = 0; k < n; k = k + 1) begin
      xbyte(wd, rx);
      rbuf[k] = rx;
    end
    cs_n_pin <= 1'b1;
    sdi_pin  <= ~sdi_pin; // Stale data never lingers between frames.
    repeat (6) @(posedge clk);
  endtask
endmodule // sfifo_host

// ==== sim/tb_sample_fifo_with_trigger_modes.sv ====
/*
  Self-checking bench of the sample buffer with a reference queue model.
  Assumes sfifo_top, sfifo_host and the bound checker are compiled before.
*/
`timescale 1ns/10ps
`include "sfifo_consts.vh"
module tb_sample_fifo_with_trigger_modes;
  logic        clk, rst, sample_valid, interrupt_active_flag;
  logic [23:0] sample_pressure;
  logic [15:0] sample_temperature;
  wire         cs_n_pin, spc_pin, sdi_pin, sdo_pin, sdo_oe_n, data_ready_irq_pin;
  wire  [7:0]  threshold_irq_cfg;
  int          n_fail, samples_checked, m_lim, m_lvl, c;
  logic [31:0] seed;
  logic [39:0] q[$];     // Expected unread records, oldest first.
  logic [39:0] last_rec; // Latest sample seen in bypass.
  logic [2:0]  m_code;
  logic        m_trig, m_ovr;
  logic [7:0]  m_route, v;

  sfifo_top dut (.clk(clk), .rst(rst), .cs_n_pin(cs_n_pin), .spc_pin(spc_pin), .sdi_pin(sdi_pin),
    .sdo_pin(sdo_pin), .sdo_oe_n(sdo_oe_n), .sample_valid(sample_valid),
    .sample_pressure(sample_pressure), .sample_temperature(sample_temperature),
    .interrupt_active_flag(interrupt_active_flag), .threshold_irq_cfg(threshold_irq_cfg),
    .data_ready_irq_pin(data_ready_irq_pin));
  sfifo_host host (.clk(clk), .cs_n_pin(cs_n_pin), .spc_pin(spc_pin), .sdi_pin(sdi_pin),
    .sdo_pin(sdo_pin), .sdo_oe_n(sdo_oe_n));

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic byp();
    return m_code[1:0] == 2'h0 || ((m_code == 3'h5 || m_code == 3'h6) && !m_trig);
  endfunction

  // Expected flag byte: watermark, overrun, full in the top three bits.
  function automatic logic [7:0] flags_exp();
    logic full, wtm;
    full = q.size() >= m_lim;
    wtm = m_lvl != 0 && q.size() >= m_lvl;
    return {wtm, m_ovr, full, 5'h00};
  endfunction

  task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic rd(input logic [6:0] a, input int n);
    host.frame({1'b1, a}, 8'h5A, n);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.frame({1'b0, a}, d, 1);
  endtask

  // Mode write; a bypass code flushes the model and drops the trigger.
  task automatic set_ctl(input logic [7:0] d);
    wr(`SFIFO_A_CTL, d);
    m_code = {d[2], d[1:0]};
    m_lim = (d[3] && m_lvl != 0) ? m_lvl : 128;
    if (d[1:0] == 2'h0) begin
      q.delete();
      m_ovr = 1'b0;
      m_trig = 1'b0;
    end
  endtask

  // Random samples, one-cycle strobes, mirrored into the model.
  task automatic push_n(input int n);
    logic [31:0] a, b;
    repeat (n) begin
      a = xs();
      b = xs();
      @(posedge clk);
      sample_valid <= 1'b1;
      sample_pressure <= a[23:0];
      sample_temperature <= b[15:0];
      @(posedge clk);
      sample_valid <= 1'b0;
      if (byp()) last_rec = {b[15:0], a[23:0]};
      else if (m_code == 3'h1 || (m_code[2] && m_trig && m_code != 3'h6)) begin
        if (q.size() < m_lim) q.push_back({b[15:0], a[23:0]});
      end else begin
        if (q.size() >= m_lim) begin
          void'(q.pop_front());
          m_ovr = 1'b1;
        end
        q.push_back({b[15:0], a[23:0]});
      end
    end
  endtask

  task automatic status();
    logic [7:0] f;
    rd(`SFIFO_A_ST1, 2);
    f = flags_exp();
    chk("count", host.rbuf[0], q.size());
    chk("flags", host.rbuf[1] & 8'hE0, f);
    chk("irq pin", data_ready_irq_pin, |(f[7:5] & {m_route[4], m_route[3], m_route[5]}));
  endtask

  // Burst of whole records from the output window, popping the model.
  task automatic recs(input int n);
    int k;
    rd(`SFIFO_A_BUF_PL, 5 * n);
    for (k = 0; k < n; k++) begin
      chk("record", {host.rbuf[5*k+4], host.rbuf[5*k+3], host.rbuf[5*k+2], host.rbuf[5*k+1],
        host.rbuf[5*k]}, byp() ? last_rec : q[0]);
      if (!byp() && q.size() > 0) begin
        void'(q.pop_front());
        m_ovr = 1'b0;
      end
    end
  endtask

  // Main sequence.
  initial begin
    rst = 1'b1;
    sample_valid = 1'b0;
    sample_pressure = 24'h000000;
    sample_temperature = 16'h0000;
    interrupt_active_flag = 1'b0;
    seed = 32'h0000005A;
    {n_fail, samples_checked, m_lvl} = '0;
    {m_code, m_trig, m_ovr, m_route} = '0;
    m_lim = 128;
    repeat (3) @(posedge clk);
    chk("reset pins", {threshold_irq_cfg, data_ready_irq_pin, sdo_oe_n}, 10'h001);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    for (c = 0; c < 8; c++) begin
      rd(c == 0 ? 7'h30 : 7'h10 + c[6:0], 1);
      chk("reset reg", host.rbuf[0], 8'h00);
    end
    wr(`SFIFO_A_WTM, 8'hFF);
    rd(`SFIFO_A_WTM, 1);
    chk("level", host.rbuf[0], 8'h7F);
    wr(`SFIFO_A_WTM, 8'h00);
    wr(`SFIFO_A_ST1, 8'hFF);
    status();
    for (c = 0; c < 2; c++) begin
      set_ctl(c == 0 ? 8'h00 : 8'h04);
      push_n(3);
      status();
      recs(1);
    end
    m_route = 8'h20;
    wr(`SFIFO_A_ROUTE, m_route);
    set_ctl(8'h01);
    push_n(130);
    status();
    recs(128);
    status();
    set_ctl(8'h00);
    m_lvl = 5;
    wr(`SFIFO_A_WTM, 8'h05);
    m_route = 8'h30;
    wr(`SFIFO_A_ROUTE, m_route);
    set_ctl(8'h09);
    push_n(7);
    status();
    rd(`SFIFO_A_BUF_PL, 4);
    status();
    recs(1);
    status();
    set_ctl(8'h00);
    m_lvl = 3;
    wr(`SFIFO_A_WTM, 8'h03);
    m_route = 8'h08;
    wr(`SFIFO_A_ROUTE, m_route);
    set_ctl(8'h0B);
    push_n(5);
    status();
    recs(3);
    push_n(1);
    recs(1);
    status();
    for (c = 5; c < 8; c++) begin
      set_ctl(8'h00);
      v = xs();
      wr(`SFIFO_A_THR_CFG, v);
      chk("cfg copy", threshold_irq_cfg, v);
      set_ctl(8'h08 | c[7:0]);
      push_n(2);
      status();
      @(posedge clk);
      interrupt_active_flag <= 1'b1;
      m_trig = 1'b1;
      rd(`SFIFO_A_SRC, 1);
      chk("active flag", host.rbuf[0] & 8'h04, 8'h04);
      push_n(4);
      status();
      recs(1);
      @(posedge clk);
      interrupt_active_flag <= 1'b0;
    end
    set_ctl(8'h00);
    set_ctl(8'h02);
    push_n(2);
    status();
    give_verdict();
  end

  // Hang guard, about 10000 cycles past the expected run length.
  initial begin
    repeat (95000) @(posedge clk);
    n_fail++;
    give_verdict();
  end
endmodule // tb_sample_fifo_with_trigger_modes
